// >>> rtl/mhs_consts.vh
// Constants for the block-transfer command interpreter.
// Included by the design, bench and monitor files; definitions only.
`ifndef MHS_CONSTS_VH
`define MHS_CONSTS_VH
// Block codes
`define MHS_C_EVT_P1 16'h03E8
`define MHS_C_EVT_P2 16'h07D0
`define MHS_C_DIS_P1 16'h0BB8
`define MHS_C_EN_P1 16'h0BB9
`define MHS_C_STL_P1 16'h0BBA
`define MHS_C_STH_P1 16'h0BBB
`define MHS_C_DIS_P2 16'h0C1C
`define MHS_C_EN_P2 16'h0C1D
`define MHS_C_STL_P2 16'h0C1E
`define MHS_C_STH_P2 16'h0C1F
// Word offsets in blocks, then list limit, status and event field counts
`define MHS_W_CODE 8'h00
`define MHS_W_ID 8'h01
`define MHS_W_RES 8'h02
`define MHS_W_LIST 8'h02
`define MHS_W_LAST 8'hF9
`define MHS_LIST_MAX 16'h00C8
`define MHS_STAT_N 8'h80
`define MHS_EVT_FIELDS 4'h9
// Slave states
`define MHS_ST_IDLE 2'h0
`define MHS_ST_OK 2'h1
`define MHS_ST_SUSP 2'h2
`define MHS_ST_DIS 2'h3
// Queue depth per port
`define MHS_Q_MAX 7'h64
// Largest accepted function code (arbitrary)
`define MHS_FUNC_MAX 16'h00FF
// Engine event kinds
`define MHS_EV_INIT 2'h0
`define MHS_EV_FAIL 2'h1
`define MHS_EV_SCAN 2'h2
// Register byte addresses and buffer address-region selects
`define MHS_A_CTRL 12'h000
`define MHS_A_STAT 12'h004
`define MHS_A_ISTAT 12'h008
`define MHS_A_IMASK 12'h00C
`define MHS_A_SUSP 12'h010
`define MHS_A_QCNT 12'h014
`define MHS_A_WBUF 2'h1
`define MHS_A_RBUF 2'h2
// Interrupt bits, then MHS_HTRANS_NSEQ for the AHB transfer type
`define MHS_I_DONE 0
`define MHS_I_IGN 1
`define MHS_I_EFAIL 2
`define MHS_HTRANS_NSEQ 1'b1
`endif

// >>> rtl/mhs_handler.v
// Block-transfer command interpreter with slave status table.
// Assumes one AHB-Lite master, and master engines on the same clock.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mhs_consts.vh"

module mhs_handler (
  // Clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Interrupt
  output wire irq,
  // Event command to master engines
  output reg evt_valid,
  output reg evt_port,
  output reg [15:0] evt_db_addr,
  output reg [15:0] evt_count,
  output reg [15:0] evt_swap,
  output reg [15:0] evt_node,
  output reg [15:0] evt_func,
  output reg [63:0] evt_params,
  output wire [1:0] q_pending,
  input wire [1:0] q_pop,
  // Engine slave events and query
  input wire eng_ev_valid,
  input wire [1:0] eng_ev_kind,
  input wire eng_ev_port,
  input wire [7:0] eng_ev_slave,
  input wire eng_q_port,
  input wire [7:0] eng_q_slave,
  output wire eng_q_allow
);

  localparam S_IDLE = 7'h01;
  localparam S_CLR = 7'h02;
  localparam S_DEC = 7'h04;
  localparam S_ZERO = 7'h08;
  localparam S_LIST = 7'h10;
  localparam S_STAT = 7'h20;
  localparam S_FIN = 7'h40;
  localparam K_EVT = 2'h0;
  localparam K_STAT = 2'h1;
  localparam K_DIS = 2'h2;
  localparam K_EN = 2'h3;

  function [8:0] tbl_addr;
    input port;
    input [7:0] idx;
    begin
      tbl_addr = {port, idx};
    end
  endfunction

  reg [15:0] wbuf [0:255];
  reg [15:0] rbuf [0:255];
  reg [1:0] tbl [0:511];
  reg [7:0] sus [0:511];

  reg [6:0] st_ff;
  reg [1:0] kind_ff;
  reg port_ff;
  reg half_ff;
  reg [15:0] code_ff;
  reg [8:0] idx_ff;
  reg [15:0] lim_ff;
  reg [15:0] res_ff;
  reg go_ff;
  reg [2:0] istat_ff;
  reg [2:0] imask_ff;
  reg [15:0] susp_ff;
  reg [6:0] qc1_ff;
  reg [6:0] qc2_ff;
  reg wr_pend_ff;
  reg [11:0] wr_addr_ff;
  reg [2:0] ev_set;
  reg known;
  reg [1:0] dk;
  reg dp;
  reg dh;

  wire ahb_take;
  wire [15:0] w0;
  wire [1:0] cur_state;
  wire push1;
  wire push2;
  wire evt_ok;
  wire [15:0] lidx;

  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign irq = |(istat_ff & imask_ff);
  assign ahb_take = ce & hsel & hready & htrans[1];
  assign w0 = wbuf[`MHS_W_CODE];
  assign q_pending = {qc2_ff != 7'h00, qc1_ff != 7'h00};
  assign cur_state = tbl[tbl_addr(eng_q_port, eng_q_slave)];
  assign eng_q_allow = (cur_state != `MHS_ST_DIS) &&
    (cur_state != `MHS_ST_SUSP);
  assign evt_ok = ((port_ff ? qc2_ff : qc1_ff) < `MHS_Q_MAX) &&
    (wbuf[8'h02] != 16'h0000) &&
    (wbuf[8'h05] <= `MHS_FUNC_MAX);
  assign push1 = st_ff[6] & ~eng_ev_valid & (kind_ff == K_EVT) &
    ~port_ff & evt_ok;
  assign push2 = st_ff[6] & ~eng_ev_valid & (kind_ff == K_EVT) &
    port_ff & evt_ok;
  assign lidx = wbuf[idx_ff[7:0] + `MHS_W_LIST];

  // AHB register bus: read data latched at address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      go_ff <= 1'b0;
      imask_ff <= 3'h0;
      susp_ff <= 16'h0000;
    end
    else if (ce)
    begin
      go_ff <= 1'b0;
      wr_pend_ff <= ahb_take & hwrite;
      if (ahb_take)
        wr_addr_ff <= haddr;
      if (ahb_take & ~hwrite)
      begin
        if (haddr[11:10] == `MHS_A_RBUF)
          hrdata <= {16'h0000, rbuf[haddr[9:2]]};
        else if (haddr[11:10] == `MHS_A_WBUF)
          hrdata <= {16'h0000, wbuf[haddr[9:2]]};
        else
        begin
          case (haddr)
            `MHS_A_STAT: hrdata <= {25'h0, st_ff};
            `MHS_A_ISTAT: hrdata <= {29'h0, istat_ff};
            `MHS_A_IMASK: hrdata <= {29'h0, imask_ff};
            `MHS_A_SUSP: hrdata <= {16'h0000, susp_ff};
            `MHS_A_QCNT: hrdata <= {9'h0, qc2_ff, 9'h0, qc1_ff};
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      end
      if (wr_pend_ff)
      begin
        case (wr_addr_ff)
          `MHS_A_CTRL: go_ff <= hwdata[0];
          `MHS_A_IMASK: imask_ff <= hwdata[2:0];
          `MHS_A_SUSP: susp_ff <= hwdata[15:0];
          default: go_ff <= 1'b0;
        endcase
      end
    end
  end

  // Write block buffer, filled by software
  always @(posedge hclk)
  begin
    if (ce && wr_pend_ff && wr_addr_ff[11:10] == `MHS_A_WBUF)
      wbuf[wr_addr_ff[9:2]] <= hwdata[15:0];
  end

  // Interrupt status, set wins over write-one clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      istat_ff <= 3'h0;
    else if (ce)
    begin
      if (wr_pend_ff && wr_addr_ff == `MHS_A_ISTAT)
        istat_ff <= (istat_ff & ~hwdata[2:0]) | ev_set;
      else
        istat_ff <= istat_ff | ev_set;
    end
  end

  always @*
  begin
    ev_set = 3'h0;
    if (st_ff[6] && !eng_ev_valid)
    begin
      ev_set[`MHS_I_DONE] = 1'b1;
      if (kind_ff == K_EVT && !evt_ok)
        ev_set[`MHS_I_EFAIL] = 1'b1;
    end
    if (st_ff[2] && !eng_ev_valid && !known)
      ev_set[`MHS_I_IGN] = 1'b1;
  end

  // Decode of block code
  always @*
  begin
    known = 1'b1;
    dk = K_EVT;
    dp = 1'b0;
    dh = 1'b0;
    case (w0)
      `MHS_C_EVT_P1: dk = K_EVT;
      `MHS_C_EVT_P2: dp = 1'b1;
      `MHS_C_STL_P1: dk = K_STAT;
      `MHS_C_STH_P1:
      begin
        dk = K_STAT;
        dh = 1'b1;
      end
      `MHS_C_STL_P2:
      begin
        dk = K_STAT;
        dp = 1'b1;
      end
      `MHS_C_STH_P2:
      begin
        dk = K_STAT;
        dp = 1'b1;
        dh = 1'b1;
      end
      `MHS_C_DIS_P1: dk = K_DIS;
      `MHS_C_DIS_P2:
      begin
        dk = K_DIS;
        dp = 1'b1;
      end
      `MHS_C_EN_P1: dk = K_EN;
      `MHS_C_EN_P2:
      begin
        dk = K_EN;
        dp = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  // Sequencer; stalls while an engine event owns the table
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= S_CLR;
      kind_ff <= K_EVT;
      port_ff <= 1'b0;
      half_ff <= 1'b0;
      code_ff <= 16'h0000;
      idx_ff <= 9'h000;
      lim_ff <= 16'h0000;
      res_ff <= 16'h0000;
      evt_valid <= 1'b0;
      evt_port <= 1'b0;
      evt_db_addr <= 16'h0000;
      evt_count <= 16'h0000;
      evt_swap <= 16'h0000;
      evt_node <= 16'h0000;
      evt_func <= 16'h0000;
      evt_params <= 64'h0;
    end
    else if (ce)
    begin
      evt_valid <= 1'b0;
      if (!eng_ev_valid)
      begin
        case (st_ff)
          S_CLR:
          begin
            idx_ff <= idx_ff + 9'h001;
            if (idx_ff == 9'h1FF)
              st_ff <= S_IDLE;
          end
          S_IDLE:
            if (go_ff)
              st_ff <= S_DEC;
          S_DEC:
          begin
            code_ff <= w0;
            kind_ff <= dk;
            port_ff <= dp;
            half_ff <= dh;
            idx_ff <= 9'h000;
            res_ff <= 16'h0000;
            lim_ff <= (wbuf[`MHS_W_ID] > `MHS_LIST_MAX) ?
              `MHS_LIST_MAX : wbuf[`MHS_W_ID];
            st_ff <= known ? S_ZERO : S_IDLE;
          end
          S_ZERO:
          begin
            idx_ff <= idx_ff + 9'h001;
            if (idx_ff[7:0] == `MHS_W_LAST)
            begin
              idx_ff <= 9'h000;
              if (kind_ff == K_STAT)
                st_ff <= S_STAT;
              else if (kind_ff == K_EVT)
                st_ff <= S_FIN;
              else
                st_ff <= S_LIST;
            end
          end
          S_STAT:
          begin
            idx_ff <= idx_ff + 9'h001;
            if (idx_ff[7:0] == `MHS_STAT_N - 8'h01)
              st_ff <= S_FIN;
          end
          S_LIST:
          begin
            if ({7'h00, idx_ff} >= lim_ff)
              st_ff <= S_FIN;
            else
            begin
              idx_ff <= idx_ff + 9'h001;
              if (lidx[15:8] == 8'h00)
                res_ff <= res_ff + 16'h0001;
            end
          end
          S_FIN:
          begin
            st_ff <= S_IDLE;
            if (kind_ff == K_EVT && evt_ok)
            begin
              evt_valid <= 1'b1;
              evt_port <= port_ff;
              evt_db_addr <= wbuf[8'h01];
              evt_count <= wbuf[8'h02];
              evt_swap <= wbuf[8'h03];
              evt_node <= wbuf[8'h04];
              evt_func <= wbuf[8'h05];
              evt_params <= {wbuf[8'h09], wbuf[8'h08],
                wbuf[8'h07], wbuf[8'h06]};
            end
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end

  // Reply block writes
  always @(posedge hclk)
  begin
    if (ce && !eng_ev_valid)
    begin
      if (st_ff == S_ZERO)
      begin
        if (idx_ff[7:0] == `MHS_W_ID || idx_ff[7:0] == `MHS_W_LAST)
          rbuf[idx_ff[7:0]] <= code_ff;
        else
          rbuf[idx_ff[7:0]] <= 16'h0000;
      end
      else if (st_ff == S_STAT)
        rbuf[idx_ff[7:0] + `MHS_W_RES] <= {14'h0,
          tbl[tbl_addr(port_ff, {half_ff, idx_ff[6:0]})]};
      else if (st_ff == S_FIN && kind_ff == K_EVT)
        rbuf[`MHS_W_RES] <= {15'h0, evt_ok};
      else if (st_ff == S_FIN)
        rbuf[`MHS_W_RES] <= res_ff;
    end
  end

  // Slave table and suspend counters
  always @(posedge hclk)
  begin
    if (ce)
    begin
      if (eng_ev_valid)
      begin
        case (eng_ev_kind)
          `MHS_EV_INIT:
            tbl[tbl_addr(eng_ev_port, eng_ev_slave)] <= `MHS_ST_OK;
          `MHS_EV_FAIL:
          begin
            tbl[tbl_addr(eng_ev_port, eng_ev_slave)] <=
              `MHS_ST_SUSP;
            sus[tbl_addr(eng_ev_port, eng_ev_slave)] <=
              eng_ev_port ? susp_ff[15:8] : susp_ff[7:0];
          end
          `MHS_EV_SCAN:
            if (tbl[tbl_addr(eng_ev_port, eng_ev_slave)] == `MHS_ST_SUSP)
            begin
              if (sus[tbl_addr(eng_ev_port, eng_ev_slave)] <= 8'h01)
              begin
                tbl[tbl_addr(eng_ev_port, eng_ev_slave)] <=
                  `MHS_ST_OK;
                sus[tbl_addr(eng_ev_port, eng_ev_slave)] <= 8'h00;
              end
              else
                sus[tbl_addr(eng_ev_port, eng_ev_slave)] <=
                  sus[tbl_addr(eng_ev_port, eng_ev_slave)] - 8'h01;
            end
          default: sus[9'h000] <= sus[9'h000];
        endcase
      end
      else if (st_ff == S_CLR)
        tbl[idx_ff] <= `MHS_ST_IDLE;
      else if (st_ff == S_LIST && {7'h00, idx_ff} < lim_ff &&
        lidx[15:8] == 8'h00)
        tbl[tbl_addr(port_ff, lidx[7:0])] <= (kind_ff == K_DIS) ?
          `MHS_ST_DIS : `MHS_ST_OK;
    end
  end

  // Queue occupancy per port
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      qc1_ff <= 7'h00;
      qc2_ff <= 7'h00;
    end
    else if (ce)
    begin
      qc1_ff <= qc1_ff + {6'h0, push1} -
        {6'h0, q_pop[0] && qc1_ff != 7'h00};
      qc2_ff <= qc2_ff + {6'h0, push2} -
        {6'h0, q_pop[1] && qc2_ff != 7'h00};
    end
  end

endmodule
`default_nettype wire

// >>> verif/mhs_engine_model.sv
// Master engine model: pops queued commands, issues slave events.
// Shares the handler clock; bench requests events through go.
`timescale 1ns/1ps
`default_nettype none
module mhs_engine_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Command queue
  input wire [1:0] q_pending,
  input wire hold,
  output logic [1:0] q_pop,
  // Slave event request
  input wire go,
  input wire [1:0] kind,
  input wire [7:0] slave,
  output logic eng_ev_valid,
  output logic [1:0] eng_ev_kind,
  output logic [7:0] eng_ev_slave
);
  logic [3:0] wait_ff;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      q_pop <= 2'h0;
      wait_ff <= 4'h0;
      eng_ev_valid <= 1'b0;
      eng_ev_kind <= 2'h0;
      eng_ev_slave <= 8'h0;
    end
    else
    begin
      q_pop <= 2'h0;
      eng_ev_valid <= go;
      // Idle values keep changing so stale ones are never trusted
      eng_ev_kind <= go ? kind : ~eng_ev_kind;
      eng_ev_slave <= go ? slave : ~eng_ev_slave;
      if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      else if (q_pending != 2'h0 && !hold)
      begin
        q_pop <= q_pending[0] ? 2'h1 : 2'h2;
        wait_ff <= 4'($urandom_range(1, 12));
      end
    end
endmodule
`default_nettype wire

// >>> verif/mhs_handler_tb.sv
// Self-checking bench for the command interpreter.
// Uses the engine model as far side; one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "mhs_consts.vh"
module mhs_handler_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic rd_ph = 1'b0, go = 1'b0, hold = 1'b1, ce = 1'b1;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0, kind = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] slave = 8'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, evt_valid, evt_port, eng_ev_valid, eng_q_allow;
  wire [15:0] evt_db_addr, evt_count, evt_swap, evt_node, evt_func;
  wire [63:0] evt_params;
  wire [1:0] q_pending, q_pop, eng_ev_kind;
  wire [7:0] eng_ev_slave;
  logic [31:0] rq[$];
  logic [144:0] eq[$];
  logic [15:0] sc[4] = '{`MHS_C_STH_P1, `MHS_C_STL_P2, `MHS_C_STH_P2,
    `MHS_C_STL_P1};
  logic [11:0] sa[4] = '{12'h81C, 12'h928, 12'h928, 12'h81C};
  logic [31:0] sv[4] = '{32'h0, 32'h0, 32'h3, 32'h3};
  int n_errors = 0, n_checks = 0;
  always #5 hclk = ~hclk;
  mhs_handler dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .evt_valid(evt_valid), .evt_port(evt_port),
    .evt_db_addr(evt_db_addr), .evt_count(evt_count), .evt_swap(evt_swap),
    .evt_node(evt_node), .evt_func(evt_func), .evt_params(evt_params),
    .q_pending(q_pending), .q_pop(q_pop), .eng_ev_valid(eng_ev_valid),
    .eng_ev_kind(eng_ev_kind), .eng_ev_port(1'b0),
    .eng_ev_slave(eng_ev_slave), .eng_q_port(1'b0), .eng_q_slave(slave),
    .eng_q_allow(eng_q_allow)
  );
  mhs_engine_model u_eng (
    .hclk(hclk), .hresetn(hresetn), .q_pending(q_pending), .hold(hold),
    .q_pop(q_pop), .go(go), .kind(kind), .slave(slave),
    .eng_ev_valid(eng_ev_valid), .eng_ev_kind(eng_ev_kind),
    .eng_ev_slave(eng_ev_slave)
  );
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail_to;
    n_errors++;
    test_done;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_e(input logic [144:0] got, input logic [144:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50)
    begin
      @(posedge hclk);
      i++;
    end
    if (i == 50)
      fail_to;
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
      rq.push_back(e);
    rd_ph <= !w;
    rdy;
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, e);
  endtask
  task automatic reply(input logic [15:0] c, input logic [31:0] w2);
    rd(12'h804, {16'h0, c});
    rd(12'h808, w2);
    rd(12'hBE4, {16'h0, c});
  endtask
  task automatic run(input logic [15:0] c, input logic [31:0] ist);
    int i;
    wr(12'h400, {16'h0, c});
    wr(`MHS_A_CTRL, 32'h1);
    // Frozen block must not finish
    if (c == `MHS_C_EN_P1)
    begin
      ce <= 1'b0;
      repeat (300)
        @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      ce <= 1'b1;
    end
    for (i = 0; i < 2000 && irq !== 1'b1; i++)
      @(posedge hclk);
    if (i == 2000)
      fail_to;
    rd(`MHS_A_ISTAT, ist);
    wr(`MHS_A_ISTAT, 32'h7);
  endtask
  task automatic evt(input logic p, input logic [15:0] cnt,
    input logic [15:0] fn, input logic ok);
    logic [15:0] w[9];
    logic [15:0] c;
    c = p ? `MHS_C_EVT_P2 : `MHS_C_EVT_P1;
    foreach (w[k])
      w[k] = 16'($urandom);
    w[1] = cnt;
    w[4] = fn;
    foreach (w[k])
      wr(12'h404 + 12'(k * 4), {16'h0, w[k]});
    if (ok)
      eq.push_back({p, w[0], w[1], w[2], w[3], w[4], w[8], w[7], w[6], w[5]});
    run(c, ok ? 32'h1 : 32'h5);
    reply(c, {31'h0, ok});
  endtask
  task automatic lst(input logic [15:0] c, input logic [31:0] n, s0, s1, s2,
    ack);
    wr(12'h404, n);
    wr(12'h408, s0);
    wr(12'h40C, s1);
    wr(12'h410, s2);
    run(c, 32'h1);
    reply(c, ack);
  endtask
  task automatic ev(input logic [1:0] k, input logic a);
    kind <= k;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (3)
      @(posedge hclk);
    chk({31'h0, eng_q_allow}, {31'h0, a});
  endtask
  // Result watcher: oldest note against each reply or command
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
      chk(hrdata, rq.pop_front());
    if (evt_valid === 1'b1)
      chk_e({evt_port, evt_db_addr, evt_count, evt_swap, evt_node, evt_func,
        evt_params}, eq.pop_front());
  end
  initial
  begin
    int i;
    void'($urandom(94));
    repeat (5)
      @(posedge hclk);
    hresetn <= 1'b1;
    repeat (520)
      @(posedge hclk);
    rd(`MHS_A_STAT, 32'h1);
    rd(`MHS_A_IMASK, 32'h0);
    rd(12'h020, 32'h0);
    wr(`MHS_A_IMASK, 32'h3);
    $display("test reset done");
    for (int k = 0; k < 100; k++)
      evt(1'b0, 16'($urandom_range(1, 65535)),
        16'($urandom_range(0, 255)), 1'b1);
    evt(1'b0, 16'h1, 16'h1, 1'b0);
    rd(`MHS_A_QCNT, 32'h64);
    evt(1'b1, 16'h1, 16'h0, 1'b1);
    evt(1'b1, 16'h0, 16'h1, 1'b0);
    evt(1'b1, 16'h1, 16'h100, 1'b0);
    hold <= 1'b0;
    for (i = 0; i < 3000 && q_pending !== 2'h0; i++)
      @(posedge hclk);
    if (i == 3000)
      fail_to;
    rd(`MHS_A_QCNT, 32'h0);
    $display("test event done");
    lst(`MHS_C_DIS_P1, 32'h3, 32'h5, 32'h6, 32'h12C, 32'h2);
    lst(`MHS_C_DIS_P2, 32'h1, 32'hC8, 32'h0, 32'h0, 32'h1);
    lst(`MHS_C_EN_P1, 32'h1, 32'h6, 32'h0, 32'h0, 32'h1);
    foreach (sc[k])
    begin
      run(sc[k], 32'h1);
      reply(sc[k], 32'h0);
      rd(sa[k], sv[k]);
    end
    rd(12'h820, 32'h1);
    rd(12'h8B8, 32'h0);
    slave <= 8'h5;
    ev(`MHS_EV_SCAN, 1'b0);
    $display("test status done");
    wr(`MHS_A_SUSP, 32'h2);
    slave <= 8'h9;
    ev(`MHS_EV_INIT, 1'b1);
    ev(`MHS_EV_FAIL, 1'b0);
    ev(`MHS_EV_SCAN, 1'b0);
    run(`MHS_C_STL_P1, 32'h1);
    rd(12'h82C, 32'h2);
    ev(`MHS_EV_SCAN, 1'b1);
    run(`MHS_C_STL_P1, 32'h1);
    rd(12'h82C, 32'h1);
    run(16'h04D2, 32'h2);
    rd(12'hBE4, {16'h0, `MHS_C_STL_P1});
    $display("test engine done");
    test_done;
  end
endmodule
`default_nettype wire

// >>> verif/mhs_monitor.sv
// Assertion checker for the command interpreter ports.
// Bound to mhs_handler; one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none
`include "mhs_consts.vh"
module mhs_monitor (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus side
  input wire ce,
  input wire hreadyout,
  input wire hresp,
  // Event command side
  input wire evt_valid,
  input wire evt_port,
  input wire [15:0] evt_count,
  input wire [15:0] evt_func,
  input wire [1:0] q_pending,
  input wire [1:0] q_pop,
  // Engine side
  input wire eng_ev_valid,
  input wire [1:0] eng_ev_kind,
  input wire eng_ev_port,
  input wire [7:0] eng_ev_slave,
  input wire eng_q_port,
  input wire [7:0] eng_q_slave,
  input wire eng_q_allow
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence quiet8;
    !evt_valid [*8];
  endsequence
  sequence hit;
    eng_ev_valid && eng_ev_port == eng_q_port && eng_ev_slave == eng_q_slave;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_ce: assert property (hreadyout == ce)
    else $error("hreadyout differs from ce");
  a_evt_single: assert property (evt_valid |=> quiet8)
    else $error("event command repeated");
  a_evt_legal: assert property (evt_valid |->
    evt_count != 16'h0 && evt_func <= `MHS_FUNC_MAX)
    else $error("invalid event command issued");
  a_evt_queued: assert property (evt_valid |=> q_pending[evt_port])
    else $error("event command not queued");
  a_pend_holds: assert property (q_pending[0] && !q_pop[0] |=>
    q_pending[0])
    else $error("queue emptied without pop");
  a_port_stands: assert property (!evt_valid |-> $stable(evt_port))
    else $error("event port moved without command");
  a_fail_blocks: assert property ((hit ##0 eng_ev_kind == `MHS_EV_FAIL)
    |=> ($stable(eng_q_slave) |-> !eng_q_allow))
    else $error("failed slave still allowed");
  a_init_allows: assert property ((hit ##0 eng_ev_kind == `MHS_EV_INIT)
    |=> ($stable(eng_q_slave) |-> eng_q_allow))
    else $error("initialised slave not allowed");
endmodule
bind mhs_handler mhs_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout),
  .hresp(hresp), .evt_valid(evt_valid), .evt_port(evt_port),
  .evt_count(evt_count), .evt_func(evt_func), .q_pending(q_pending),
  .q_pop(q_pop), .eng_ev_valid(eng_ev_valid), .eng_ev_kind(eng_ev_kind),
  .eng_ev_port(eng_ev_port), .eng_ev_slave(eng_ev_slave),
  .eng_q_port(eng_q_port), .eng_q_slave(eng_q_slave),
  .eng_q_allow(eng_q_allow)
);
`default_nettype wire
